/* test/lbm_bus_model.sv */
// Far-side memory model for the local bus master
`timescale 1ns/1ps
module lbm_bus_model (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic [31:0] i_ad_out,
   input wire logic i_ad_oe,
   input wire logic i_ale_n,
   input wire logic i_ale_oe,
   input wire logic i_den_n,
   input wire logic i_w_r,
   input wire logic [1:0] i_waits,
   output logic [31:0] o_ad,
   output logic o_ready_n,
   output logic o_wseen,
   output logic o_aseen,
   output logic [31:0] o_seen_data
);
   logic [7:0] cnt_q;
   logic [31:0] last_q;
   logic [31:0] addr_q;
   logic ale_q;
   wire [7:0] ph = cnt_q >> 1;
   wire [7:0] per = {6'h00, i_waits} + 8'h01;
   wire [7:0] beat = ph / per;
   wire den = !i_den_n;
   wire ale = i_ale_oe && !i_ale_n;
   // Ready only in the last phase of each beat, after the wait phases
   assign o_ready_n = !(den && (ph % per) == {6'h00, i_waits});
   // Read data while enabled; a floating bus shows a changing pattern
   assign o_ad = i_ad_oe ? i_ad_out : (den && !i_w_r) ? addr_q + beat * 32'h0001_0001 : ~last_q;
   // Phase counter, address capture and beat reports
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_q <= 8'h00;
         last_q <= 32'h0000_0000;
         addr_q <= 32'h0000_0000;
         ale_q <= 1'b0;
         o_aseen <= 1'b0;
         o_wseen <= 1'b0;
         o_seen_data <= 32'h0000_0000;
      end else begin
         cnt_q <= den ? cnt_q + 8'h01 : 8'h00;
         last_q <= o_ad;
         ale_q <= ale;
         if (ale) begin
            addr_q <= i_ad_out;
         end
         o_aseen <= ale && !ale_q;
         o_wseen <= den && !o_ready_n && i_w_r && cnt_q[0];
         o_seen_data <= i_ad_out;
      end
   end
endmodule

/* test/lbm_master_tb.sv */
// Self-checking testbench of the local bus master
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin ev = (ex); compares++; if ((gt) !== ev) begin bad_count++; $display("ERROR %s expected %h seen %h", nm, ev, gt); end end
module lbm_master_tb;
   import lbm_pkg::*;
   logic i_sys_clk, i_rst_n, i_cmd_valid, i_cmd_write, i_wd_valid, i_ready_n;
   logic [LBM_ADDR_W-1:0] i_cmd_addr;
   logic [LBM_SIZE_W-1:0] i_cmd_len;
   logic [LBM_DATA_W-1:0] i_wd_data, i_ad, o_ad, o_rd_data, seen_data, ev, seed;
   logic o_cmd_ack, o_wd_ready, o_rd_valid, o_ad_oe, o_ale_n, o_ale_oe, o_w_r, o_den_n, wseen, aseen, r;
   logic [1:0] waits;
   logic [LBM_DATA_W-1:0] exp_rd[$], exp_wr[$], exp_adr[$];
   int bad_count, compares, acc;
   // ***********************************
   // Clock, design and far-side model
   // ***********************************
   initial begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = ~i_sys_clk;
   end
   lbm_master dut (.i_sys_clk, .i_rst_n, .i_cmd_valid, .i_cmd_write, .i_cmd_addr, .i_cmd_len, .o_cmd_ack,
      .i_wd_valid, .i_wd_data, .o_wd_ready, .o_rd_valid, .o_rd_data, .i_ad, .o_ad, .o_ad_oe, .o_ale_n,
      .o_ale_oe, .o_astb_n(), .o_astb_oe(), .o_w_r, .o_dir(), .o_den_n, .o_den_oe(), .i_ready_n);
   lbm_bus_model m (.i_sys_clk, .i_rst_n, .i_ad_out(o_ad), .i_ad_oe(o_ad_oe), .i_ale_n(o_ale_n),
      .i_ale_oe(o_ale_oe), .i_den_n(o_den_n), .i_w_r(o_w_r), .i_waits(waits), .o_ad(i_ad),
      .o_ready_n(i_ready_n), .o_wseen(wseen), .o_aseen(aseen), .o_seen_data(seen_data));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task summarize;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task timeout;
      bad_count++;
      $display("ERROR wait expected done seen expiry");
      summarize;
   endtask
   // Offer one write word and hold it until taken
   task push(input logic [31:0] d);
      int n;
      n = 0;
      while (o_wd_ready !== 1'b1) begin
         @(negedge i_sys_clk);
         n++;
         if (n > 200) timeout;
      end
      i_wd_valid = 1'b1;
      i_wd_data = d;
      exp_wr.push_back(d);
      @(negedge i_sys_clk);
   endtask
   // One access with random word address; pre means data already buffered
   task access(input logic wr, input logic [1:0] l, input logic pre);
      int n;
      logic [31:0] w;
      seed = lfsr(seed);
      w = {seed[31:2], l};
      exp_adr.push_back(w);
      for (int k = 0; k <= l; k++) begin
         if (!wr) exp_rd.push_back(w + k * 32'h0001_0001);
         else if (!pre) begin
            seed = lfsr(seed);
            push(seed);
         end
      end
      i_wd_valid = 1'b0;
      i_cmd_valid = 1'b1;
      i_cmd_write = wr;
      i_cmd_addr = w[31:2];
      i_cmd_len = l;
      n = 0;
      do begin
         @(negedge i_sys_clk);
         n++;
         if (n > 200) timeout;
      end while (o_cmd_ack !== 1'b1);
      i_cmd_valid = 1'b0;
      // Let an edge pass so the next call does not re-raise valid in this step
      @(negedge i_sys_clk);
   endtask
   task drain;
      int n;
      n = 0;
      while (exp_rd.size() + exp_wr.size() + exp_adr.size() != 0 || o_den_n !== 1'b1) begin
         @(negedge i_sys_clk);
         n++;
         if (n > 2000) timeout;
      end
   endtask
   // Match each observed result against the oldest note
   always @(posedge i_sys_clk) begin
      #1;
      if (o_rd_valid === 1'b1) `CHK("read_data", exp_rd.size() ? exp_rd.pop_front() : 'x, o_rd_data)
      if (wseen === 1'b1) `CHK("write_data", exp_wr.size() ? exp_wr.pop_front() : 'x, seen_data)
      if (aseen === 1'b1) `CHK("addr_word", exp_adr.size() ? exp_adr.pop_front() : 'x, seen_data)
   end
   // ***********************************
   // Main sequence
   // ***********************************
   initial begin
      {i_rst_n, i_cmd_valid, i_cmd_write, i_wd_valid, waits} = '0;
      i_cmd_addr = '0;
      i_cmd_len = '0;
      i_wd_data = '0;
      seed = 32'h0000_dd31;
      repeat (3) @(negedge i_sys_clk);
      i_rst_n = 1'b1;
      @(negedge i_sys_clk);
      // Every size code both ways, chained, with zero to two waits
      for (int w = 0; w < 3; w++) begin
         waits = 2'(w);
         for (int j = 0; j < 8; j++) access(j[0], 2'(j / 2), 1'b0);
         drain;
      end
      // Fill the buffer until it refuses, then drain it with stalls
      acc = 0;
      i_wd_valid = 1'b1;
      for (int j = 0; j < 12; j++) begin
         seed = lfsr(seed);
         i_wd_data = seed;
         r = o_wd_ready;
         @(negedge i_sys_clk);
         if (r === 1'b1) begin
            exp_wr.push_back(i_wd_data);
            acc++;
         end
      end
      `CHK("fifo_words", LBM_FIFO_DEPTH, acc)
      access(1'b1, 2'h3, 1'b1);
      access(1'b1, 2'h3, 1'b1);
      drain;
      `CHK("fifo_ready", 1'b1, o_wd_ready)
      summarize;
   end
endmodule

/* verilog/lbm_fifo.sv */
// Write data FIFO with valid and ready on both sides
`timescale 1ns/1ps
module lbm_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   lbm_fifo_if.fifo f
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [CW-1:0] count_q;
   logic [CW-1:0] count_d;
   logic rdy_q;
   logic push;
   logic pop;

   // Handshakes and occupancy
   assign push = f.in_valid && rdy_q;
   assign pop = f.out_valid && f.out_ready;
   assign count_d = count_q + CW'(push) - CW'(pop);
   assign f.in_ready = rdy_q;
   assign f.out_valid = (count_q != '0);
   assign f.out_data = mem_q[rd_ptr_q];
   assign f.count = count_q;

   // Storage
   always_ff @(posedge i_sys_clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= f.in_data;
      end
   end

   // Pointers, count and registered ready
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
         rdy_q <= 1'b0;
      end else begin
         wr_ptr_q <= push ? AW'(wr_ptr_q + 1'b1) : wr_ptr_q;
         rd_ptr_q <= pop ? AW'(rd_ptr_q + 1'b1) : rd_ptr_q;
         count_q <= count_d;
         rdy_q <= (count_d != FULL_CNT);
      end
   end
endmodule

/* verilog/lbm_fifo_if.sv */
// Interface carrying the write data FIFO signals between the bus master and its buffer
`timescale 1ns/1ps
interface lbm_fifo_if #(parameter int W = 32, parameter int CW = 4) ();
   logic in_valid;
   logic in_ready;
   logic [W-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [W-1:0] out_data;
   logic [CW-1:0] count;

   modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data, count);
   modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data, count);
endinterface

/* verilog/lbm_master.sv */
// Multiplexed local address/data bus master with burst, wait and ready handling
// Summary of operation
// - Bus states advance on clock halved internally.
// - Address state drives word address plus size.
// - Data state: all lines carry transfer data.
// - Size code gives burst of one-four words.
// - Address/data lines float unless driving address/write.
// - Latch enable low in address state only.
// - Strobe each address state, off next data.
// - Burst: strobe again after ready-acknowledged data.
// - Write/read held valid through data, waits.
// - Direction low for reads, high for writes.
// - Direction never changes while data enabled.
// - Data enable asserted in data, wait states.
// - No ready: insert wait, no strobe.
`timescale 1ns/1ps
module lbm_master
   import lbm_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_cmd_valid,
   input wire logic i_cmd_write,
   input wire logic [LBM_ADDR_W-1:0] i_cmd_addr,
   input wire logic [LBM_SIZE_W-1:0] i_cmd_len,
   output logic o_cmd_ack,
   input wire logic i_wd_valid,
   input wire logic [LBM_DATA_W-1:0] i_wd_data,
   output logic o_wd_ready,
   output logic o_rd_valid,
   output logic [LBM_DATA_W-1:0] o_rd_data,
   input wire logic [LBM_DATA_W-1:0] i_ad,
   output logic [LBM_DATA_W-1:0] o_ad,
   output logic o_ad_oe,
   output logic o_ale_n,
   output logic o_ale_oe,
   output logic o_astb_n,
   output logic o_astb_oe,
   output logic o_w_r,
   output logic o_dir,
   output logic o_den_n,
   output logic o_den_oe,
   input wire logic i_ready_n
);
   // ************************************************************
   // Declarations and helpers
   // ************************************************************
   lbm_fifo_if #(.W(LBM_DATA_W), .CW(LBM_FIFO_CNT_W)) wd_if ();

   lbm_state_e state_q;
   lbm_state_e state_d;
   logic ce_q;
   logic wr_q;
   logic [LBM_SIZE_W-1:0] beat_q;
   logic ready_seen;
   logic in_xfer;
   logic last_beat;
   logic word_done;
   logic can_start;
   logic take_cmd;
   logic enter_data;
   logic nxt_xfer;
   logic nxt_write;
   logic astb_d;
   logic ad_oe_d;
   logic [LBM_DATA_W-1:0] ad_d;

   // Start only when a write has all its words buffered
   function automatic logic f_can_start(input logic valid, input logic write,
                                        input logic [LBM_SIZE_W-1:0] len,
                                        input logic [LBM_FIFO_CNT_W-1:0] cnt);
      f_can_start = valid && (!write || (cnt > LBM_FIFO_CNT_W'(len)));
   endfunction

   // ************************************************************
   // Write data buffer
   // ************************************************************
   lbm_fifo #(.WIDTH(LBM_DATA_W), .DEPTH(LBM_FIFO_DEPTH)) u_wd_fifo (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .f(wd_if.fifo)
   );

   // Buffer fill side and drain on each write data beat
   assign wd_if.in_valid = i_wd_valid;
   assign wd_if.in_data = i_wd_data;
   assign wd_if.out_ready = enter_data && nxt_write;
   assign o_wd_ready = wd_if.in_ready;

   // ************************************************************
   // Phase divider
   // ************************************************************
   // One enable pulse every second system clock
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ce_q <= 1'b0;
      end else begin
         ce_q <= !ce_q;
      end
   end

   // ************************************************************
   // Bus sequencer
   // ************************************************************
   // Decodes of the current phase
   assign ready_seen = (i_ready_n == LBM_ASSERT_N);
   assign in_xfer = (state_q == LBM_ST_DATA) || (state_q == LBM_ST_WAIT);
   assign last_beat = (beat_q == LBM_SIZE_ONE);
   assign word_done = in_xfer && ready_seen;
   assign can_start = f_can_start(i_cmd_valid, i_cmd_write, i_cmd_len, wd_if.count);

   // Next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         LBM_ST_IDLE: begin
            if (can_start) begin
               state_d = LBM_ST_ADDR;
            end
         end
         LBM_ST_ADDR: begin
            state_d = LBM_ST_DATA;
         end
         LBM_ST_DATA, LBM_ST_WAIT: begin
            if (!ready_seen) begin
               state_d = LBM_ST_WAIT;
            end else if (!last_beat) begin
               state_d = LBM_ST_DATA;
            end else if (can_start) begin
               state_d = LBM_ST_ADDR;
            end else begin
               state_d = LBM_ST_IDLE;
            end
         end
         default: begin
            state_d = LBM_ST_IDLE;
         end
      endcase
   end

   // Strobes of the step about to be taken
   assign take_cmd = ce_q && (state_d == LBM_ST_ADDR);
   assign enter_data = ce_q && (state_d == LBM_ST_DATA);
   assign nxt_xfer = (state_d == LBM_ST_DATA) || (state_d == LBM_ST_WAIT);
   assign nxt_write = (state_d == LBM_ST_ADDR) ? i_cmd_write : wr_q;
   assign astb_d = (state_d == LBM_ST_ADDR) || ((state_d == LBM_ST_DATA) && word_done);
   assign ad_oe_d = (state_d == LBM_ST_ADDR) || (nxt_xfer && nxt_write);

   // Address word with size, or next write word, or hold through waits
   assign ad_d = (state_d == LBM_ST_ADDR) ? {i_cmd_addr, i_cmd_len} :
                 (enter_data && nxt_write) ? wd_if.out_data : o_ad;

   // State, direction latch and beat count
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= LBM_ST_IDLE;
         wr_q <= 1'b0;
         beat_q <= LBM_SIZE_ONE;
      end else if (ce_q) begin
         state_q <= state_d;
         if (take_cmd) begin
            wr_q <= i_cmd_write;
            beat_q <= i_cmd_len;
         end else if (word_done && !last_beat) begin
            beat_q <= beat_q - LBM_SIZE_STEP;
         end
      end
   end

   // ************************************************************
   // Registered pins
   // ************************************************************
   // Pin levels follow the state being entered
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ad <= LBM_DATA_RST;
         o_ad_oe <= 1'b0;
         o_ale_n <= LBM_NEGATE_N;
         o_ale_oe <= 1'b0;
         o_astb_n <= LBM_NEGATE_N;
         o_astb_oe <= 1'b0;
         o_w_r <= 1'b0;
         o_dir <= 1'b0;
         o_den_n <= LBM_NEGATE_N;
         o_den_oe <= 1'b0;
      end else if (ce_q) begin
         o_ad <= ad_d;
         o_ad_oe <= ad_oe_d;
         o_ale_n <= !(state_d == LBM_ST_ADDR);
         o_ale_oe <= (state_d != LBM_ST_IDLE);
         o_astb_n <= !astb_d;
         o_astb_oe <= astb_d;
         o_w_r <= nxt_write;
         o_dir <= nxt_write;
         o_den_n <= !nxt_xfer;
         o_den_oe <= nxt_xfer;
      end
   end

   // Command acknowledge and read data capture, one-cycle pulses
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_cmd_ack <= 1'b0;
         o_rd_valid <= 1'b0;
         o_rd_data <= LBM_DATA_RST;
      end else begin
         o_cmd_ack <= take_cmd;
         o_rd_valid <= ce_q && word_done && !wr_q;
         if (ce_q && word_done && !wr_q) begin
            o_rd_data <= i_ad;
         end
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_beat_ack;
      ce_q && word_done && !last_beat;
   endsequence

   sequence s_no_ready;
      ce_q && in_xfer && !ready_seen;
   endsequence

   a_phase_halved: assert property (ce_q |=> !ce_q ##1 ce_q)
      else $error("phase enable not every second clock");
   a_addr_word: assert property ((state_q == LBM_ST_ADDR) |-> o_ad_oe && o_ad[1:0] == beat_q)
      else $error("address state without size on low bits");
   a_data_drive: assert property (in_xfer |-> (o_ad_oe == wr_q))
      else $error("data lines driven in wrong direction");
   a_float_idle: assert property ((state_q == LBM_ST_IDLE) |-> !o_ad_oe && !o_ale_oe)
      else $error("lines not released when idle");
   a_latch_addr: assert property ((o_ale_n == LBM_ASSERT_N) |-> (state_q == LBM_ST_ADDR))
      else $error("latch enable outside address state");
   a_ads_first: assert property ((state_q == LBM_ST_DATA) && $past(state_q == LBM_ST_ADDR) |-> o_astb_n)
      else $error("strobe held into first data state");
   a_ads_burst: assert property (s_beat_ack |=> !o_astb_n && (state_q == LBM_ST_DATA))
      else $error("strobe missing after acknowledged beat");
   a_wait_insert: assert property (s_no_ready |=> ((state_q == LBM_ST_WAIT) && o_astb_n)[*2])
      else $error("wait state not inserted on missing ready");
   a_dir_hold: assert property (in_xfer |-> (o_w_r == wr_q) && (o_dir == wr_q))
      else $error("direction qualifiers differ from latched access");
   a_dir_stable: assert property (!o_den_n && $past(!o_den_n) |-> $stable(o_dir))
      else $error("direction changed while data enabled");
   a_den_data: assert property ((o_den_n == LBM_ASSERT_N) == in_xfer)
      else $error("data enable not matching data or wait state");
   a_last_end: assert property (ce_q && word_done && last_beat |=> (state_q == LBM_ST_IDLE) ||
                                (state_q == LBM_ST_ADDR))
      else $error("transfer did not end after last word");
   a_read_take: assert property (ce_q && word_done && !wr_q |=> o_rd_valid && o_rd_data == $past(i_ad))
      else $error("read word not captured on ready");
endmodule

/* verilog/lbm_pkg.sv */
// Constants, field layout and state encoding of the local bus master
package lbm_pkg;
   localparam int LBM_DATA_W = 32;
   localparam int LBM_ADDR_W = 30;
   localparam int LBM_SIZE_W = 2;
   localparam int LBM_FIFO_DEPTH = 8;
   localparam int LBM_FIFO_CNT_W = 4;
   // Size field sits in bits 0-1, word address in bits 2-31 of the address word
   localparam int LBM_SIZE_LSB = 0;
   localparam int LBM_ADDR_LSB = 2;
   localparam logic [LBM_SIZE_W-1:0] LBM_SIZE_ONE = 2'h0;
   localparam logic [LBM_SIZE_W-1:0] LBM_SIZE_STEP = 2'h1;
   localparam logic LBM_ASSERT_N = 1'b0;
   localparam logic LBM_NEGATE_N = 1'b1;
   localparam logic [LBM_DATA_W-1:0] LBM_DATA_RST = 32'h0000_0000;

   typedef enum logic [3:0] {
      LBM_ST_IDLE = 4'h1,
      LBM_ST_ADDR = 4'h2,
      LBM_ST_DATA = 4'h4,
      LBM_ST_WAIT = 4'h8
   } lbm_state_e;
endpackage
